// file: afa_flag_aggregator.sv
// Operation
// RULE1: selected event sets flag, raises remote alarm
// RULE2: filter bit zero masks its alarm
// RULE3: all filter bits zero after reset
// RULE4: all registers share alarm bit layout
// RULE5: chosen flags clear when cause vanishes
// RULE6: clear with live cause re-sets, re-alarms
// RULE7: critical bits cleared only by zero write
// RULE8: all fraud causes share one bit
// RULE9: separate on and off status per set
// RULE10: status bits stay until client clears
// RULE11: flag rise sets matching descriptor bit
// RULE12: flag clears leave descriptors unchanged
// RULE13: descriptors cleared only by client write
// RULE14: three descriptor, alarm, filter registers
// RULE15: set three bits 15, 16 supply switch
// RULE16: set three bit 24 neutral and open
// RULE17: set three bit 25 second input
// RULE18: on status at rise, off at fall
// RULE19: set three reserved bits stay zero
`timescale 1ns/1ps
`default_nettype none
module afa_flag_aggregator
	import afa_pkg::*;
(
	input  wire logic                 sys_clk,
	input  wire logic                 rst,
	input  wire logic [31:0]          cond_set1,
	input  wire logic [AFA_NFRAUD-1:0] fraud_cause,
	input  wire logic [31:0]          cond_set2,
	input  wire logic                 supply_to_main,
	input  wire logic                 supply_to_aux,
	input  wire logic                 neutral_open,
	input  wire logic                 alarm_in2,
	input  wire logic                 acc_req,
	input  wire logic                 acc_wr,
	input  wire logic [AFA_IDX_W-1:0] acc_idx,
	input  wire logic [31:0]          acc_wdata,
	input  wire logic                 acc_from_hec,
	output logic                      acc_ack,
	output logic                      acc_err,
	output logic      [31:0]          acc_rdata,
	output logic                      remote_alarm_port
);
	// ==========================================
	// declarations
	logic [31:0] cond_v [AFA_SETS];
	logic [31:0] flg [AFA_SETS];
	logic [31:0] flt [AFA_SETS];
	logic [31:0] ons [AFA_SETS];
	logic [31:0] offs [AFA_SETS];
	logic [31:0] dsc [AFA_SETS];
	logic [31:0] alm_clr_w [AFA_SETS];
	logic [31:0] on_clr_w [AFA_SETS];
	logic [31:0] off_clr_w [AFA_SETS];
	logic [31:0] dsc_clr_w [AFA_SETS];
	logic [AFA_SETS-1:0] hit_w;
	logic [AFA_SETS-1:0] flt_wr_w;
	logic [AFA_SETS-1:0] dsc_wr_w;
	logic [AFA_SETS-1:0] on_wr_w;
	logic [AFA_SETS-1:0] raise_w;
	logic [1:0] set_sel;
	logic [1:0] set_idx;
	logic [2:0] kind;
	logic map_ok;
	logic alm1_wr;
	logic [31:0] crit_clr;
	logic crit_viol;
	logic err_d;
	logic wr_ok;
	logic rd_ok;
	logic [31:0] rd_word;
	logic [31:0] rdata_d;
	logic ack_q;
	logic err_q;
	logic [31:0] rdata_q;
	logic alarm_q;
	logic fraud_any;
	logic [31:0] cond3;

	// ==========================================
	// event conditions
	// every fraud cause folds onto one bit
	assign fraud_any = |fraud_cause; // [RULE8]

	// set one with fraud bit replaced
	assign cond_v[0] = {cond_set1[31:AFA_FRAUD_BIT+1],
		fraud_any,
		cond_set1[AFA_FRAUD_BIT-1:0]}; // [RULE8]
	assign cond_v[1] = cond_set2;

	// set three: only four live bits
	always_comb
	begin
		cond3 = AFA_ZERO; // [RULE19]
		cond3[AFA_BIT_MAIN] = supply_to_main; // [RULE15]
		cond3[AFA_BIT_AUX] = supply_to_aux; // [RULE15]
		cond3[AFA_BIT_NEUT] = neutral_open; // [RULE16]
		cond3[AFA_BIT_IN2] = alarm_in2; // [RULE17]
	end
	assign cond_v[2] = cond3;

	// ==========================================
	// client access decode
	// index splits into set and register kind
	assign set_sel = acc_idx[4:3];
	assign kind = acc_idx[2:0];
	assign map_ok = (set_sel <= AFA_SET_LAST) && (kind <= AFA_KIND_DSC);
	assign set_idx = map_ok ? set_sel : 2'h0;

	// critical bits of set one guarded
	assign alm1_wr = acc_req && acc_wr && (acc_idx == AFA_IDX_ALM1);
	assign crit_clr = flg[0] & ~acc_wdata & AFA_CRIT_MASK;
	assign crit_viol = alm1_wr && (|crit_clr)
		&& (!acc_from_hec || (acc_wdata != AFA_ZERO)); // [RULE7]

	// refused: unmapped index or guarded clear
	assign err_d = acc_req && (!map_ok || crit_viol); // [RULE7]
	assign wr_ok = acc_req && acc_wr && map_ok && !crit_viol;
	assign rd_ok = acc_req && !acc_wr && map_ok;

	// ==========================================
	// per set storage and write strobes
	// three sets, same bit map each, own self clearing and implemented bits
	genvar s;
	generate
		for (s = 0; s < AFA_SETS; s++)
		begin : g_set
			// write strobes for this set
			assign hit_w[s] = wr_ok && (set_sel == 2'(s));
			assign flt_wr_w[s] = hit_w[s] && (kind == AFA_KIND_FLT);
			assign dsc_wr_w[s] = hit_w[s] && (kind == AFA_KIND_DSC);
			assign on_wr_w[s] = hit_w[s] && (kind == AFA_KIND_ON);

			// written zeros clear bits
			assign alm_clr_w[s] = (hit_w[s] && (kind == AFA_KIND_ALM))
				? ~acc_wdata : AFA_ZERO; // [RULE6]
			assign on_clr_w[s] = on_wr_w[s] ? ~acc_wdata : AFA_ZERO; // [RULE10]
			assign off_clr_w[s] = (hit_w[s] && (kind == AFA_KIND_OFF))
				? ~acc_wdata : AFA_ZERO; // [RULE10]
			assign dsc_clr_w[s] = dsc_wr_w[s] ? ~acc_wdata : AFA_ZERO; // [RULE13]

			// flags, filter, on/off status, descriptor
			afa_set #(
				.AUTO_MASK (AFA_AUTO[s]),
				.IMPL_MASK (AFA_IMPL[s])
			) u_set (
				.sys_clk   (sys_clk),
				.rst       (rst),
				.cond      (cond_v[s]),
				.flt_wr    (flt_wr_w[s]),
				.flt_wdata (acc_wdata),
				.alm_clr   (alm_clr_w[s]),
				.on_clr    (on_clr_w[s]),
				.off_clr   (off_clr_w[s]),
				.dsc_clr   (dsc_clr_w[s]),
				.flags     (flg[s]),
				.filter    (flt[s]),
				.on_stat   (ons[s]),
				.off_stat  (offs[s]),
				.desc      (dsc[s]),
				.raise     (raise_w[s])
			); // [RULE4] [RULE9] [RULE14]

			// ==========================================
			// checks per set
			// masked bit never rises
			a_masked_no_rise: assert property ( // [RULE2]
				@(posedge sys_clk) disable iff (rst)
				((flg[s] & ~$past(flg[s]) & ~$past(flt[s])) == AFA_ZERO))
			else $error("flag rose under a cleared filter bit");

			// enabled live cause shows next cycle
			a_event_sets: assert property ( // [RULE1]
				@(posedge sys_clk) disable iff (rst)
				(|(cond_v[s] & flt[s])) |=>
				((flg[s] & $past(cond_v[s] & flt[s]))
				== $past(cond_v[s] & flt[s])))
			else $error("enabled event did not set its flag");

			// every rise is in the descriptor
			a_desc_on_rise: assert property ( // [RULE11]
				@(posedge sys_clk) disable iff (rst)
				((flg[s] & ~$past(flg[s]) & ~dsc[s]) == AFA_ZERO))
			else $error("descriptor missed a flag rise");

			// descriptor falls only after a client write
			a_desc_sticky: assert property ( // [RULE12] [RULE13]
				@(posedge sys_clk) disable iff (rst)
				((($past(dsc[s]) & ~dsc[s]) != AFA_ZERO) |->
				$past(dsc_wr_w[s])))
			else $error("descriptor bit dropped without write");

			// on status falls only after a client write
			a_on_sticky: assert property ( // [RULE10]
				@(posedge sys_clk) disable iff (rst)
				((($past(ons[s]) & ~ons[s]) != AFA_ZERO) |->
				$past(on_wr_w[s])))
			else $error("on status dropped without write");

			// every fall lands in the off status
			a_off_on_fall: assert property ( // [RULE18]
				@(posedge sys_clk) disable iff (rst)
				(($past(flg[s]) & ~flg[s] & ~offs[s]) == AFA_ZERO))
			else $error("off status missed a flag fall");

			// every rise lands in the on status
			a_on_on_rise: assert property ( // [RULE18]
				@(posedge sys_clk) disable iff (rst)
				((flg[s] & ~$past(flg[s]) & ~ons[s]) == AFA_ZERO))
			else $error("on status missed a flag rise");

			// off status falls only after a client write
			a_off_sticky: assert property ( // [RULE10]
				@(posedge sys_clk) disable iff (rst)
				((($past(offs[s]) & ~offs[s]) != AFA_ZERO) |->
				($past(off_clr_w[s]) != AFA_ZERO)))
			else $error("off status dropped without write");

			// self clearing bits drop once the cause is gone
			a_auto_clear: assert property ( // [RULE5]
				@(posedge sys_clk) disable iff (rst)
				((flg[s] & $past(~cond_v[s]) & AFA_AUTO[s]) == AFA_ZERO))
			else $error("self clearing flag stayed set");
		end
	endgenerate

	// ==========================================
	// read mux and answer registers
	// select the addressed register
	assign rd_word = (kind == AFA_KIND_ALM) ? flg[set_idx]
		: (kind == AFA_KIND_FLT) ? flt[set_idx]
		: (kind == AFA_KIND_ON) ? ons[set_idx]
		: (kind == AFA_KIND_OFF) ? offs[set_idx]
		: dsc[set_idx];
	// read data holds between reads
	assign rdata_d = rd_ok ? rd_word : rdata_q;

	// one cycle answer to every request
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			ack_q <= 1'b0;
			err_q <= 1'b0;
			rdata_q <= AFA_ZERO;
			alarm_q <= 1'b0;
		end
		else
		begin
			ack_q <= acc_req;
			err_q <= err_d; // [RULE7]
			rdata_q <= rdata_d;
			alarm_q <= |raise_w; // [RULE1] [RULE6]
		end
	end

	// outputs
	assign acc_ack = ack_q;
	assign acc_err = err_q;
	assign acc_rdata = rdata_q;
	assign remote_alarm_port = alarm_q;

	// ==========================================
	// checks across the block
	// filters empty right after reset
	a_filter_reset: assert property ( // [RULE3]
		@(posedge sys_clk)
		$past(rst) && !rst |->
		(flt[0] == AFA_ZERO) && (flt[1] == AFA_ZERO) && (flt[2] == AFA_ZERO))
	else $error("filter not zero after reset");

	// any flag rise pulses the alarm port
	a_rise_alarm: assert property ( // [RULE1]
		@(posedge sys_clk) disable iff (rst)
		((|(flg[0] & ~$past(flg[0]))) || (|(flg[1] & ~$past(flg[1])))
		|| (|(flg[2] & ~$past(flg[2])))) |-> remote_alarm_port)
	else $error("flag rise without remote alarm");

	// set three unused bits stay low
	a_reserved_zero: assert property ( // [RULE19]
		@(posedge sys_clk) disable iff (rst)
		((flg[2] & ~AFA_IMPL[2]) == AFA_ZERO)
		&& ((dsc[2] & ~AFA_IMPL[2]) == AFA_ZERO))
	else $error("reserved bit of set three is set");

	// guarded clear attempt
	sequence s_crit_try;
		acc_req && acc_wr && (acc_idx == AFA_IDX_ALM1) && crit_viol;
	endsequence

	// refused clear: error answer, critical bits kept
	a_crit_guard: assert property ( // [RULE7]
		@(posedge sys_clk) disable iff (rst)
		s_crit_try |=> acc_err
		&& (($past(flg[0]) & ~flg[0] & AFA_CRIT_MASK) == AFA_ZERO))
	else $error("critical clear not refused");

	// client clear while cause persists
	sequence s_clear_live;
		wr_ok && (kind == AFA_KIND_ALM)
		&& (|(alm_clr_w[set_idx] & cond_v[set_idx] & flt[set_idx]));
	endsequence

	// re-set at once and alarm reissued
	a_reissue: assert property ( // [RULE6]
		@(posedge sys_clk) disable iff (rst)
		s_clear_live |=> remote_alarm_port
		&& (|(flg[$past(set_idx)] & $past(alm_clr_w[set_idx]))))
	else $error("live cause not re-raised after clear");

	// all fraud causes reach the shared bit
	a_fraud_map: assert property ( // [RULE8]
		@(posedge sys_clk) disable iff (rst)
		(|fraud_cause) && flt[0][AFA_FRAUD_BIT] |=> flg[0][AFA_FRAUD_BIT])
	else $error("fraud cause did not set shared bit");

	// aux supply switch bit maps as fixed
	a_supply_map: assert property ( // [RULE15] aux supply switch bit
		@(posedge sys_clk) disable iff (rst)
		(supply_to_aux && flt[2][AFA_BIT_AUX]) ##1 supply_to_main
		|-> flg[2][AFA_BIT_AUX])
	else $error("aux supply switch not flagged");

	// neutral missing with open switch flagged
	a_neutral_map: assert property ( // [RULE16]
		@(posedge sys_clk) disable iff (rst)
		neutral_open && flt[2][AFA_BIT_NEUT] |=> flg[2][AFA_BIT_NEUT])
	else $error("neutral missing not flagged");

	// second alarm input flagged
	a_input2_map: assert property ( // [RULE17]
		@(posedge sys_clk) disable iff (rst)
		alarm_in2 && flt[2][AFA_BIT_IN2] |=> flg[2][AFA_BIT_IN2])
	else $error("second alarm input not flagged");

	// head-end all-zero clear accepted, only live causes remain
	a_crit_allowed: assert property ( // [RULE7]
		@(posedge sys_clk) disable iff (rst)
		alm1_wr && acc_from_hec && (acc_wdata == AFA_ZERO) |=> !acc_err
		&& ((flg[0] & ~$past(cond_v[0] & flt[0])) == AFA_ZERO))
	else $error("head-end clear was refused");

	// every request answered next cycle
	a_ack_once: assert property (
		@(posedge sys_clk) disable iff (rst)
		acc_req |=> acc_ack ##1 (acc_ack == $past(acc_req)))
	else $error("request not answered in one cycle");
endmodule
`default_nettype wire

// file: afa_hec_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// head-end client: issues register reads and clearing writes
module afa_hec_model
(
	input  wire logic        sys_clk,
	input  wire logic        acc_ack,
	input  wire logic        acc_err,
	input  wire logic [31:0] acc_rdata,
	output logic             acc_req,
	output logic             acc_wr,
	output logic      [4:0]  acc_idx,
	output logic      [31:0] acc_wdata,
	output logic             acc_from_hec
);
	// idle bus at time zero
	initial
	begin
		acc_req = 1'b0;
		acc_wr = 1'b0;
		acc_idx = 5'h00;
		acc_wdata = 32'h0000_0000;
		acc_from_hec = 1'b0;
	end

	// one request held over its taking edge; statuses and descriptors
	// are only ever cleared by these writes
	task automatic access(input logic wr, input logic [4:0] idx, input logic [31:0] wd,
		input logic hec, output logic [31:0] rd, output logic ak, output logic er);
		@(posedge sys_clk);
		acc_req <= 1'b1;
		acc_wr <= wr;
		acc_idx <= idx;
		acc_wdata <= wd;
		acc_from_hec <= hec;
		@(posedge sys_clk);
		acc_req <= 1'b0;
		acc_wdata <= ~wd; // released data does not keep its value
		// registered answer stands at the following edge
		@(posedge sys_clk);
		rd = acc_rdata;
		ak = acc_ack;
		er = acc_err;
	endtask
endmodule
`default_nettype wire

// file: afa_pkg.sv
`default_nettype none
// ==========================================
// shared constants of the alarm aggregator
package afa_pkg;
	// register geometry
	localparam int AFA_W = 32;
	localparam int AFA_SETS = 3;
	localparam int AFA_IDX_W = 5;
	localparam int AFA_NFRAUD = 6;

	// access index: set number in [4:3], kind in [2:0]
	localparam logic [2:0] AFA_KIND_ALM = 3'h0;
	localparam logic [2:0] AFA_KIND_FLT = 3'h1;
	localparam logic [2:0] AFA_KIND_ON = 3'h2;
	localparam logic [2:0] AFA_KIND_OFF = 3'h3;
	localparam logic [2:0] AFA_KIND_DSC = 3'h4;
	localparam logic [1:0] AFA_SET_LAST = 2'h2;
	localparam logic [4:0] AFA_IDX_ALM1 = 5'h00;

	// reset and fixed values
	localparam logic [31:0] AFA_ZERO = 32'h0000_0000;
	localparam logic [31:0] AFA_FLT_RST = 32'h0000_0000;
	localparam logic [31:0] AFA_CRIT_MASK = 32'h0000_ff00;

	// bit positions
	localparam int AFA_FRAUD_BIT = 13;
	localparam int AFA_BIT_MAIN = 15;
	localparam int AFA_BIT_AUX = 16;
	localparam int AFA_BIT_NEUT = 24;
	localparam int AFA_BIT_IN2 = 25;

	// bits that exist per set
	localparam logic [31:0] AFA_IMPL [AFA_SETS] = '{
		32'hffff_ffff, 32'hffff_ffff, 32'h0301_8000};
	// bits that clear themselves when the cause goes away
	localparam logic [31:0] AFA_AUTO [AFA_SETS] = '{
		32'hff00_0000, 32'h0001_c000, 32'h0001_8000};
endpackage
`default_nettype wire

// file: afa_set.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// one alarm set: flags, filter, statuses, descriptor
module afa_set
	import afa_pkg::*;
#(
	parameter logic [31:0] AUTO_MASK = 32'h0000_0000,
	parameter logic [31:0] IMPL_MASK = 32'hffff_ffff
)
(
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic [31:0] cond,
	input  wire logic        flt_wr,
	input  wire logic [31:0] flt_wdata,
	input  wire logic [31:0] alm_clr,
	input  wire logic [31:0] on_clr,
	input  wire logic [31:0] off_clr,
	input  wire logic [31:0] dsc_clr,
	output logic      [31:0] flags,
	output logic      [31:0] filter,
	output logic      [31:0] on_stat,
	output logic      [31:0] off_stat,
	output logic      [31:0] desc,
	output logic             raise
);
	logic [31:0] flags_q, flags_d;
	logic [31:0] filter_q, filter_d;
	logic [31:0] on_q, on_d;
	logic [31:0] off_q, off_d;
	logic [31:0] desc_q, desc_d;
	logic [31:0] hit, gone, newb, fall;

	// ==========================================
	// flag update
	// selected events only, unused bits stay low
	assign hit = cond & filter_q & IMPL_MASK; // [RULE1] [RULE2] [RULE19]
	// self clearing once the cause is gone
	assign gone = flags_q & AUTO_MASK & ~cond; // [RULE5]
	// a live cause beats a clear in the same cycle
	assign flags_d = (flags_q & ~alm_clr & ~gone) | hit; // [RULE6]
	// rising bits, including re-raise after a client clear
	assign newb = hit & (~flags_q | alm_clr); // [RULE6] [RULE11]
	assign fall = flags_q & ~flags_d;

	// ==========================================
	// sticky records
	// only a client write clears, sets win
	assign on_d = (on_q & ~on_clr) | newb; // [RULE10] [RULE18]
	assign off_d = (off_q & ~off_clr) | fall; // [RULE10] [RULE18]
	// flag clears leave the descriptor alone
	assign desc_d = (desc_q & ~dsc_clr) | newb; // [RULE11] [RULE12] [RULE13]
	assign filter_d = flt_wr ? (flt_wdata & IMPL_MASK) : filter_q;

	// state registers
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			flags_q <= AFA_ZERO;
			filter_q <= AFA_FLT_RST; // [RULE3]
			on_q <= AFA_ZERO;
			off_q <= AFA_ZERO;
			desc_q <= AFA_ZERO;
		end
		else
		begin
			flags_q <= flags_d;
			filter_q <= filter_d;
			on_q <= on_d;
			off_q <= off_d;
			desc_q <= desc_d;
		end
	end

	// outputs
	assign flags = flags_q;
	assign filter = filter_q;
	assign on_stat = on_q;
	assign off_stat = off_q;
	assign desc = desc_q;
	assign raise = |newb; // [RULE1]
endmodule
`default_nettype wire

// file: tb_alarm_flag_aggregator.sv
`timescale 1ns/1ps
`default_nettype none
module tb_alarm_flag_aggregator
	import afa_pkg::*;
;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic [31:0] c1 = 32'h0000_0000;
	logic [31:0] c2 = 32'h0000_0000;
	logic [5:0]  fr = 6'h00;
	logic        smain = 1'b0;
	logic        saux = 1'b0;
	logic        neut = 1'b0;
	logic        in2 = 1'b0;
	logic        acc_req, acc_wr, acc_from_hec, acc_ack, acc_err, remote_alarm_port;
	logic [4:0]  acc_idx;
	logic [31:0] acc_wdata, acc_rdata, exp_rd;
	logic        exp_err, exp_rem;
	logic [31:0] m [5][3];
	logic [31:0] cn [3];
	int          n_fail = 0;
	int          total_checks = 0;

	always #10 sys_clk = ~sys_clk;

	// ==========================================
	// design and client
	afa_flag_aggregator u_afa_flag_aggregator (.sys_clk(sys_clk), .rst(rst), .cond_set1(c1),
		.fraud_cause(fr), .cond_set2(c2), .supply_to_main(smain), .supply_to_aux(saux),
		.neutral_open(neut), .alarm_in2(in2), .acc_req(acc_req), .acc_wr(acc_wr),
		.acc_idx(acc_idx), .acc_wdata(acc_wdata), .acc_from_hec(acc_from_hec),
		.acc_ack(acc_ack), .acc_err(acc_err), .acc_rdata(acc_rdata),
		.remote_alarm_port(remote_alarm_port));
	afa_hec_model u_afa_hec_model (.sys_clk(sys_clk), .acc_ack(acc_ack), .acc_err(acc_err),
		.acc_rdata(acc_rdata), .acc_req(acc_req), .acc_wr(acc_wr), .acc_idx(acc_idx),
		.acc_wdata(acc_wdata), .acc_from_hec(acc_from_hec));

	// ==========================================
	// reference model: kind x set registers
	assign cn[0] = (c1 & ~32'h0000_2000) | {18'h0, |fr, 13'h0};
	assign cn[1] = c2;
	assign cn[2] = {6'h0, in2, neut, 7'h0, saux, smain, 15'h0};

	always @(posedge sys_clk)
	begin
		logic [31:0] clr [5];
		logic [31:0] live, nf, rise;
		logic [1:0]  s;
		logic [2:0]  k;
		logic        bad, rem, we;
		s = acc_idx[4:3];
		k = acc_idx[2:0];
		bad = acc_req && (s == 2'h3 || k > 3'h4);
		if (acc_req && acc_wr && acc_idx == AFA_IDX_ALM1 && !(acc_from_hec && acc_wdata == 0))
			bad = |(m[0][0] & AFA_CRIT_MASK & ~acc_wdata);
		rem = 1'b0;
		for (int i = 0; i < 3; i++)
		begin
			we = acc_req && acc_wr && !bad && s == i;
			for (int j = 0; j < 5; j++)
				clr[j] = (we && k == j) ? ~acc_wdata : 32'h0000_0000;
			live = cn[i] & m[1][i];
			nf = (m[0][i] & ~clr[0] & ~(AFA_AUTO[i] & ~cn[i])) | live;
			rise = nf & ~(m[0][i] & ~clr[0]);
			rem = rem | (|rise);
			m[2][i] <= rst ? 32'h0 : (m[2][i] & ~clr[2]) | rise;
			m[3][i] <= rst ? 32'h0 : (m[3][i] & ~clr[3]) | (m[0][i] & ~nf);
			m[4][i] <= rst ? 32'h0 : (m[4][i] & ~clr[4]) | rise;
			m[0][i] <= rst ? 32'h0 : nf;
			if (rst || (we && k == 3'h1))
				m[1][i] <= rst ? AFA_FLT_RST : acc_wdata & AFA_IMPL[i];
		end
		if (acc_req && !acc_wr && !bad)
			exp_rd <= m[k][s];
		exp_err <= bad;
		exp_rem <= rem && !rst;
	end

	// ==========================================
	// compares and accesses
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_bit(input logic got, input logic exp);
		cmp({31'h0, got}, {31'h0, exp});
	endtask

	task automatic acc(input logic wr, input logic [4:0] idx, input logic [31:0] wd,
		input logic hec);
		logic [31:0] rd;
		logic        ak, er;
		u_afa_hec_model.access(wr, idx, wd, hec, rd, ak, er);
		cmp_bit(ak, 1'b1);
		cmp_bit(er, exp_err);
		if (!wr && !exp_err)
			cmp(rd, exp_rd);
	endtask

	// read every register of every set
	task automatic dump;
		for (int i = 0; i < 15; i++)
			acc(1'b0, 5'((i / 5) * 8 + i % 5), 32'h0, 1'b0);
	endtask

	task automatic finish_test;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// remote alarm pulse checked every cycle
	always @(negedge sys_clk)
		if (!rst)
			cmp_bit(remote_alarm_port, exp_rem);

	// ==========================================
	// tests
	initial
	begin
		void'($urandom(32'h028b_2d1f));
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		dump();
		acc(1'b0, 5'h1d, 32'h0, 1'b0); // unmapped set and kind
		acc(1'b0, 5'h18, 32'h0, 1'b0); // unmapped set
		$display("test reset_values done");
		acc(1'b1, 5'h01, $urandom, 1'b0);
		acc(1'b1, 5'h09, 32'hffff_ffff, 1'b0);
		c1 <= $urandom;
		c2 <= $urandom;
		fr <= 6'h04;
		repeat (3) @(posedge sys_clk);
		c1 <= 32'h0000_0000;
		c2 <= 32'h0000_4001;
		fr <= 6'h00;
		dump();
		$display("test filtered_events done");
		acc(1'b1, 5'h01, 32'hffff_ffff, 1'b0);
		c1 <= 32'h0000_ff00;
		fr <= 6'h20;
		@(posedge sys_clk);
		c1 <= 32'h0000_0300;
		acc(1'b1, 5'h00, 32'h0, 1'b0);
		acc(1'b1, 5'h00, 32'hffff_00ff, 1'b1);
		acc(1'b1, 5'h00, 32'hffff_ffff, 1'b0);
		acc(1'b1, 5'h00, 32'h0, 1'b1);
		dump();
		$display("test critical_clear done");
		acc(1'b1, 5'h11, 32'hffff_ffff, 1'b0);
		{smain, saux, neut, in2} <= 4'hf;
		repeat (2) @(posedge sys_clk);
		{smain, saux} <= 2'h0;
		dump();
		for (int i = 0; i < 3; i++)
			for (int j = 0; j < 5; j++)
				acc(1'b1, 5'(i * 8 + j), (j == 1) ? 32'hffff_ffff : 32'h0, 1'b1);
		dump();
		$display("test status_clear done");
		c1 <= $urandom;
		c2 <= $urandom;
		repeat (2) @(posedge sys_clk);
		for (int i = 0; i < 40; i++)
		begin
			logic [4:0] ix;
			logic       wr;
			ix = 5'($urandom);
			wr = (ix[2:0] != 3'h1) && 1'($urandom);
			acc(wr, ix, $urandom & $urandom, 1'($urandom));
		end
		dump();
		$display("test random_access done");
		finish_test();
	end

	// watchdog against a hung run
	initial
	begin
		repeat (6000) @(posedge sys_clk);
		n_fail++;
		finish_test();
	end
endmodule
`default_nettype wire
